// ==== core/serial_map.svh ====
// register map, field positions, reset values and bit timing
// assumes: included by the core module only; the serial control package does not include it
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH
// byte offsets on the bus (low address byte)
`define OFS_FRAME    8'h00
`define OFS_TXRX     8'h04
`define OFS_NINTH    8'h08
`define OFS_STATUS   8'h0c
`define OFS_DATA     8'h10
// frame control fields
`define FC_MOD_EN    6
`define FC_NINE      4
`define FC_WAKE      3
`define FC_IDLE_COUNT_TYPE      2
`define FC_PAR_EN    1
`define FC_PAR_ODD   0
`define FC_MASK      8'h5f
// tx/rx control fields
`define TR_TXE_IE    7
`define TR_TC_IE     6
`define TR_RXF_IE    5
`define TR_IDLE_IE   4
`define TR_TX_EN     3
`define TR_RX_EN     2
`define TR_STANDBY   1
`define TR_BREAK     0
// ninth bit / error enable fields
`define NB_RX9       7
`define NB_TX9       6
// receive flag vector positions
`define RF_FULL      5
`define RF_IDLE      4
`define RF_OVR       3
`define RF_NOISE     2
`define RF_FRAME     1
`define RF_PAR       0
// reset values
`define CTRL_RST     8'h00
`define FLAGS_RST    6'h00
// bit period in clocks and half of it, then frame lengths in bits for 8-bit and 9-bit frames
`define BIT_CYCLES   8'd16
`define HALF_BIT     8'd8
`define LEN_EIGHT    4'd10
`define LEN_NINE     4'd11
`endif

// ==== core/serial_pkg.sv ====
// types shared by the serial control block
// assumes: constants come from serial_map.svh
package serial_pkg;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
endpackage

// ==== core/async_serial_control_status.sv ====
// serial control/status registers, transmitter and receiver
// assumes: one ahb-lite master, hclk 200 MHz, rxd_pin asynchronous
// Function
// RL1 - wake select: address mark or idle
// RL2 - idle count starts after stop or start
// RL3 - parity enable puts parity in msb
// RL4 - parity type odd or even
// RL5 - tx empty flag raises tx interrupt
// RL6 - tx complete flag raises tx interrupt
// RL7 - rx full flag raises rx interrupt
// RL8 - rx idle flag raises rx interrupt
// RL9 - enabling transmitter sends ones preamble
// RL10 - disabling transmitter finishes character, line high
// RL11 - re-enable during character queues idle character
// RL12 - no enable writes while module disabled
// RL13 - receiver enable; disable keeps flags
// RL14 - standby masks rx interrupts until wake
// RL15 - break then one; held gives back-to-back
// RL16 - break before preamble replaces the preamble
// RL17 - received ninth bit captured with data
// RL18 - tx ninth bit loads with data
// RL19 - enabled error flags raise error interrupt
// RL20 - tx empty sets on load, read/write clears
// RL21 - tx complete high when nothing sending
// RL22 - start lags queuing by little time
// RL23 - module disable sets tx flags, masks
// RL24 - rx full cleared by status/data reads
// RL25 - three level interrupt outputs
`timescale 1ns/1ps
`include "serial_map.svh"
module async_serial_control_status
  import serial_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd_pin,
  output logic             txd,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             err_irq
);

  // parity bit over eight bits; odd adds an inversion
  function automatic logic par_bit(input logic [7:0] v,
                                   input logic odd);
    par_bit = (^v) ^ odd;
  endfunction

  logic [7:0]  frame_ctl;
  logic [7:0]  txrx_ctl;
  logic        tx_ninth_bit;
  logic        rx_ninth_bit;
  logic [3:0]  err_en;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] rd_value;
  tx_state_t   tx_state;
  logic [10:0] tx_shift;
  logic [3:0]  tx_left;
  logic [7:0]  tx_tmr;
  logic        pend_ones;
  logic        post_break;
  logic [7:0]  tx_buf;
  logic        tx_empty_flag;
  logic        tx_complete_flag;
  logic        tx_arm;
  rx_state_t   rx_state;
  logic        rx_s1;
  logic        rx_s2;
  logic        rx_prev;
  logic [7:0]  rx_tmr;
  logic [3:0]  rx_cnt;
  logic [9:0]  rx_sh;
  logic [3:0]  ones;
  logic        idle_armed;
  logic        noisy;
  logic        wake_pulse;
  logic [5:0]  rx_flags;
  logic [5:0]  rx_arm;
  logic [7:0]  rx_data;

  wire take      = hsel && hready && htrans[1];
  wire rd_status = take && !hwrite && haddr[7:0] == `OFS_STATUS;
  wire rd_data   = take && !hwrite && haddr[7:0] == `OFS_DATA;
  wire wr_txrx   = wr_pend && wr_addr == `OFS_TXRX;
  wire wr_data   = wr_pend && wr_addr == `OFS_DATA;

  wire module_enable     = frame_ctl[`FC_MOD_EN];
  wire nine_bit          = frame_ctl[`FC_NINE];
  wire wake_addr         = frame_ctl[`FC_WAKE];
  wire idle_count_type   = frame_ctl[`FC_IDLE_COUNT_TYPE];
  wire parity_enable     = frame_ctl[`FC_PAR_EN];
  wire parity_odd_select = frame_ctl[`FC_PAR_ODD];
  wire transmitter_enable = txrx_ctl[`TR_TX_EN];
  wire receiver_enable   = txrx_ctl[`TR_RX_EN];
  wire receiver_standby  = txrx_ctl[`TR_STANDBY];
  wire send_break        = txrx_ctl[`TR_BREAK];
  wire [3:0] flen        = nine_bit ? `LEN_NINE : `LEN_EIGHT;

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase latched for the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    if (haddr[7:0] == `OFS_FRAME) begin
      rd_value = {24'h000000, frame_ctl};
    end else if (haddr[7:0] == `OFS_TXRX) begin
      rd_value = {24'h000000, txrx_ctl};
    end else if (haddr[7:0] == `OFS_NINTH) begin
      rd_value = {24'h000000, rx_ninth_bit, tx_ninth_bit, 2'b00, err_en};
    end else if (haddr[7:0] == `OFS_STATUS) begin
      rd_value = {24'h000000, tx_empty_flag, tx_complete_flag, rx_flags};
    end else if (haddr[7:0] == `OFS_DATA) begin
      rd_value = {24'h000000, rx_data};
    end else begin
      rd_value = 32'h00000000;
    end
  end

  // read data sampled in the address phase so no wait state is needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= rd_value;
    end
  end

  // control registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_ctl    <= `CTRL_RST;
      txrx_ctl     <= `CTRL_RST;
      tx_ninth_bit <= 1'b0; // RL18
      err_en       <= 4'h0; // RL19
    end else begin
      if (wr_pend && wr_addr == `OFS_FRAME) begin
        frame_ctl <= hwdata[7:0] & `FC_MASK;
      end else if (wr_txrx) begin
        txrx_ctl[7:4] <= hwdata[7:4];
        txrx_ctl[1:0] <= hwdata[1:0];
        // enables ignored while the module is off
        if (module_enable) begin
          txrx_ctl[3:2] <= hwdata[3:2]; // RL12
        end
      end else if (wr_pend && wr_addr == `OFS_NINTH) begin
        tx_ninth_bit <= hwdata[`NB_TX9];
        err_en       <= hwdata[3:0];
      end
      // wake wins over a same-cycle software write
      if (wake_pulse) begin
        txrx_ctl[`TR_STANDBY] <= 1'b0; // RL14
      end
    end
  end

  // transmit frame: start, data (parity in msb), stop, lsb first
  logic [8:0]  tx_word;
  logic [10:0] tx_frame;
  always_comb begin
    tx_word = {tx_ninth_bit, tx_buf}; // RL18
    if (parity_enable && nine_bit) begin
      tx_word[8] = par_bit(tx_buf, parity_odd_select); // RL3 RL4
    end else if (parity_enable) begin
      tx_word[7] = par_bit({1'b0, tx_buf[6:0]}, parity_odd_select);
    end
    tx_frame = nine_bit ? {1'b1, tx_word, 1'b0}
                        : {2'b11, tx_word[7:0], 1'b0};
  end

  wire te_rise   = wr_txrx && hwdata[`TR_TX_EN] && !transmitter_enable
                   && module_enable;
  wire can_load  = tx_state == TX_IDLE && transmitter_enable;
  wire load_brk  = can_load && send_break;
  wire load_one  = can_load && !send_break && post_break;
  wire load_pre  = can_load && !send_break && !post_break && pend_ones;
  wire load_data = can_load && !send_break && !post_break && !pend_ones
                   && !tx_empty_flag;

  // transmitter: queue, shifter, empty flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state      <= TX_IDLE;
      tx_shift      <= 11'h000;
      tx_left       <= 4'h0;
      tx_tmr        <= 8'h00;
      pend_ones     <= 1'b0;
      post_break    <= 1'b0;
      tx_buf        <= 8'h00;
      tx_empty_flag <= 1'b1; // RL20
      tx_arm        <= 1'b0;
      txd           <= 1'b1;
    end else if (!module_enable) begin
      tx_state      <= TX_IDLE;
      pend_ones     <= 1'b0;
      post_break    <= 1'b0;
      tx_empty_flag <= 1'b1; // RL23
      tx_arm        <= 1'b0;
      txd           <= 1'b1;
    end else begin
      // preamble on enable, or one idle character if mid-frame
      if (te_rise) begin
        pend_ones <= 1'b1; // RL9 RL11
      end
      if (rd_status && tx_empty_flag) begin
        tx_arm <= 1'b1;
      end
      if (wr_data) begin
        tx_buf <= hwdata[7:0];
        tx_arm <= 1'b0;
        if (tx_arm) begin
          tx_empty_flag <= 1'b0; // RL20
        end
      end
      case (tx_state)
        TX_IDLE: begin
          // loading starts the line on the next edge
          if (load_brk) begin
            txd        <= 1'b0; // RL15 RL22
            tx_shift   <= 11'h000;
            tx_left    <= flen - 4'd1;
            pend_ones  <= 1'b0; // RL16
            post_break <= 1'b1;
          end else if (load_one) begin
            txd        <= 1'b1; // RL15
            tx_left    <= 4'h0;
            post_break <= 1'b0;
          end else if (load_pre) begin
            txd       <= 1'b1; // RL9
            tx_shift  <= 11'h7ff;
            tx_left   <= flen - 4'd1;
            pend_ones <= 1'b0;
          end else if (load_data) begin
            txd           <= tx_frame[0];
            tx_shift      <= {1'b1, tx_frame[10:1]};
            tx_left       <= flen - 4'd1;
            tx_empty_flag <= 1'b1; // RL20
          end else begin
            txd <= 1'b1; // RL10
          end
          if (can_load && (send_break || post_break || pend_ones
                           || !tx_empty_flag)) begin
            tx_state <= TX_SHIFT;
            tx_tmr   <= `BIT_CYCLES - 8'd1;
          end
        end
        TX_SHIFT: begin
          // line holds the last bit until the next load decides
          if (tx_tmr != 8'h00) begin
            tx_tmr <= tx_tmr - 8'd1;
          end else if (tx_left == 4'h0) begin
            tx_state <= TX_IDLE; // RL10
          end else begin
            txd      <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_left  <= tx_left - 4'd1;
            tx_tmr   <= `BIT_CYCLES - 8'd1;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // complete flag follows empty and an idle shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_complete_flag <= 1'b1; // RL21
    end else begin
      tx_complete_flag <= !module_enable || (tx_empty_flag // RL23
        && tx_state == TX_IDLE && !pend_ones && !post_break
        && !(transmitter_enable && send_break) && !te_rise); // RL21
    end
  end

  // receive line synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1   <= rxd_pin;
      rx_s2   <= rx_s1;
      rx_prev <= rx_s2;
    end
  end

  wire rx_active = module_enable && receiver_enable; // RL13
  wire rx_tick   = rx_active && rx_tmr == 8'h00;
  wire rx_done   = rx_tick && rx_state == RX_BITS && rx_cnt == 4'd1;
  wire [9:0] rx_vec  = {rx_s2, rx_sh[9:1]};
  wire [8:0] rx_word = nine_bit ? rx_vec[8:0] : {1'b0, rx_vec[8:1]};
  wire rx_msb    = nine_bit ? rx_word[8] : rx_word[7];
  wire rx_accept = !receiver_standby || (wake_addr && rx_msb); // RL1
  wire rx_store  = rx_done && rx_accept && !rx_flags[`RF_FULL];
  // ones at a bit sample; before the stop only when counting from start
  wire count_one = rx_tick && rx_s2 && ones != flen
    && (rx_state == RX_IDLE || (rx_state == RX_BITS && !idle_count_type));
  wire idle_hit  = count_one && ones == flen - 4'd1;

  // data and ninth bit have no reset; captured together
  always_ff @(posedge hclk) begin
    if (rx_store) begin
      rx_data      <= rx_word[7:0];
      rx_ninth_bit <= rx_msb; // RL17
    end
  end

  // receiver sequencer, flags and wake detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state   <= RX_IDLE;
      rx_tmr     <= 8'h00;
      rx_cnt     <= 4'h0;
      rx_sh      <= 10'h000;
      ones       <= 4'h0;
      idle_armed <= 1'b0;
      noisy      <= 1'b0;
      wake_pulse <= 1'b0;
      rx_flags   <= `FLAGS_RST; // RL24
      rx_arm     <= 6'h00;
    end else begin
      wake_pulse <= 1'b0;
      // two-step clear: status read arms, data read clears
      if (rd_status) begin
        rx_arm <= rx_flags;
      end
      if (rd_data) begin
        rx_flags <= rx_flags & ~rx_arm; // RL24
        rx_arm   <= 6'h00;
      end
      if (count_one) begin
        ones <= ones + 4'd1;
      end
      // idle wakes standby without flagging, else flags once armed
      if (idle_hit && receiver_standby && !wake_addr) begin
        wake_pulse <= 1'b1; // RL1 RL14
      end else if (idle_hit && idle_armed && !receiver_standby) begin
        rx_flags[`RF_IDLE] <= 1'b1;
        idle_armed         <= 1'b0;
      end
      if (!rx_active) begin
        rx_state <= RX_IDLE; // RL13
        ones     <= 4'h0;
      end else begin
        case (rx_state)
          RX_IDLE: begin
            if (!rx_s2) begin
              rx_state <= RX_START;
              rx_tmr   <= `HALF_BIT - 8'd1;
            end else if (rx_tmr == 8'h00) begin
              rx_tmr <= `BIT_CYCLES - 8'd1;
            end else begin
              rx_tmr <= rx_tmr - 8'd1;
            end
          end
          RX_START: begin
            if (rx_tmr != 8'h00) begin
              rx_tmr <= rx_tmr - 8'd1;
            end else if (rx_s2) begin
              rx_state <= RX_IDLE; // false start
            end else begin
              rx_state <= RX_BITS;
              rx_cnt   <= flen - 4'd1;
              rx_tmr   <= `BIT_CYCLES - 8'd1;
              ones     <= 4'h0; // RL2
              noisy    <= 1'b0;
            end
          end
          RX_BITS: begin
            if (rx_tmr != 8'h00) begin
              rx_tmr <= rx_tmr - 8'd1;
            end else begin
              rx_sh  <= rx_vec;
              rx_cnt <= rx_cnt - 4'd1;
              rx_tmr <= `BIT_CYCLES - 8'd1;
              // level change right before a sample counts as noise
              noisy  <= noisy || rx_s2 != rx_prev;
              if (!rx_s2) begin
                ones <= 4'h0; // RL2
              end
              if (rx_cnt == 4'd1) begin
                rx_state <= RX_IDLE;
              end
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
      // a finished frame; sets win over same-cycle clears
      if (rx_done && rx_accept) begin
        if (receiver_standby) begin
          wake_pulse <= 1'b1; // RL1 RL14
        end
        if (rx_flags[`RF_FULL]) begin
          rx_flags[`RF_OVR] <= 1'b1;
        end else begin
          rx_flags[`RF_FULL] <= 1'b1;
          idle_armed         <= 1'b1;
        end
        if (!rx_vec[9]) begin
          rx_flags[`RF_FRAME] <= 1'b1;
        end
        if (parity_enable && (^rx_word) != parity_odd_select) begin
          rx_flags[`RF_PAR] <= 1'b1; // RL3 RL4
        end
        if (noisy || rx_s2 != rx_prev) begin
          rx_flags[`RF_NOISE] <= 1'b1;
        end
      end
    end
  end

  // level interrupt requests, one per source group
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_irq  <= 1'b0;
      rx_irq  <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      tx_irq <= module_enable && // RL23 RL25
        ((tx_empty_flag && txrx_ctl[`TR_TXE_IE]) || // RL5
         (tx_complete_flag && txrx_ctl[`TR_TC_IE])); // RL6
      rx_irq <= !receiver_standby && // RL14 RL25
        ((rx_flags[`RF_FULL] && txrx_ctl[`TR_RXF_IE]) || // RL7
         (rx_flags[`RF_IDLE] && txrx_ctl[`TR_IDLE_IE])); // RL8
      err_irq <= |(rx_flags[3:0] & err_en); // RL19 RL25
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_preamble_start: assert property ( // RL9
    te_rise && tx_state == TX_IDLE && !send_break && !hwdata[0]
      |=> pend_ones ##1 (tx_state == TX_SHIFT && txd))
    else $error("preamble not started after transmitter enable");
  a_break_low: assert property ( // RL15
    load_brk && module_enable |=> !txd && tx_state == TX_SHIFT)
    else $error("break character does not drive line low");
  a_line_idle: assert property ( // RL10
    module_enable && !transmitter_enable && tx_state == TX_IDLE |=> txd)
    else $error("line not idle with transmitter disabled");
  a_empty_on_load: assert property ( // RL20
    load_data && module_enable |=> tx_empty_flag && tx_state == TX_SHIFT)
    else $error("empty flag not set on shifter load");
  a_busy_not_done: assert property ( // RL21
    (tx_state == TX_SHIFT && module_enable)[*2] |-> !tx_complete_flag)
    else $error("complete flag high while shifting");
  a_disable_flags: assert property ( // RL23
    (!module_enable)[*2] |-> tx_empty_flag && tx_complete_flag && !tx_irq)
    else $error("module disable did not set flags or mask irq");
  a_full_clear: assert property ( // RL24
    rd_data && rx_arm[`RF_FULL] && !rx_done |=> !rx_flags[`RF_FULL])
    else $error("rx full not cleared by data read");
  a_standby_mask: assert property ( // RL14
    receiver_standby |=> !rx_irq)
    else $error("receiver interrupt while in standby");
  a_error_irq: assert property ( // RL19
    rx_flags[`RF_FRAME] && err_en[`RF_FRAME] |=> err_irq)
    else $error("framing error did not raise error interrupt");
  a_ninth_capture: assert property ( // RL17
    rx_store |=> rx_ninth_bit == $past(rx_msb) && rx_flags[`RF_FULL])
    else $error("ninth bit not captured with data");

  c_data_frame: cover property (load_data ##1 tx_state == TX_SHIFT);
  c_back_break: cover property (load_brk ##[1:400] load_brk);
  c_rx_full:    cover property (rx_store ##1 rx_irq);
  c_idle_flag:  cover property ($rose(rx_flags[`RF_IDLE]));

endmodule

// ==== testbench/serial_node_model.sv ====
// remote serial node: sends frames on rxd_pin, decodes frames from txd
// assumes: 16 clocks per bit, 8-bit frames, lsb first, idle high
`timescale 1ns/1ps
module serial_node_model (
  input  wire logic       clk,
  input  wire logic       txd,
  input  wire logic       send_go,
  input  wire logic [7:0] send_byte,
  input  wire logic       send_stop,
  output logic            rxd_pin,
  output logic            got_stb,
  output logic [7:0]      got_byte
);
  logic [7:0] sb;
  logic       ss;

  initial begin
    rxd_pin = 1'b1;
    got_stb = 1'b0;
    got_byte = 8'h00;
  end

  // frame out; a stop of 0 is only sent when the bench asks for it
  always @(posedge clk) begin
    if (send_go) begin
      sb = send_byte;
      ss = send_stop;
      rxd_pin <= 1'b0;
      repeat (16) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        rxd_pin <= sb[i];
        repeat (16) @(posedge clk);
      end
      rxd_pin <= ss;
      repeat (16) @(posedge clk);
      rxd_pin <= 1'b1; // line back to idle level
    end
  end

  // frame in: find start edge, sample mid-bit
  always begin
    @(negedge txd);
    repeat (8) @(posedge clk);
    for (int j = 0; j < 8; j++) begin
      repeat (16) @(posedge clk);
      got_byte[j] <= txd;
    end
    repeat (16) @(posedge clk);
    got_stb <= 1'b1;
    @(posedge clk);
    got_stb <= 1'b0;
  end
endmodule

// ==== testbench/async_serial_control_status_test.sv ====
// self-checking bench for the serial control/status block
// assumes: zero-wait ahb-lite slave, one remote node on the serial lines
`timescale 1ns/1ps
module async_serial_control_status_test;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, rxd_pin, txd, tx_irq, rx_irq, err_irq;
  logic        send_go = 1'b0;
  logic [7:0]  send_byte = 8'h00;
  logic        send_stop = 1'b1;
  logic        got_stb, rd_ph = 1'b0;
  logic [7:0]  got_byte, rx_b;
  logic [31:0] exp_q[$], msk_q[$], rd_m;
  logic [7:0]  fr_q[$];
  integer      seed = 32'hc95e9125;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #2.5 hclk = ~hclk;

  async_serial_control_status async_serial_control_status_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxd_pin(rxd_pin), .txd(txd), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .err_irq(err_irq));

  serial_node_model serial_node_model_i (
    .clk(hclk), .txd(txd), .send_go(send_go), .send_byte(send_byte),
    .send_stop(send_stop), .rxd_pin(rxd_pin), .got_stb(got_stb),
    .got_byte(got_byte));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // single ahb transfer; reads leave their expectation in the queue
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    rd_ph <= ~wr;
    if (!wr) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  // bounded wait for an interrupt line to rise
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    check({31'h0, s}, 32'h1);
  endtask

  task automatic send(input logic [7:0] b, input logic stp);
    @(posedge hclk);
    send_byte <= b;
    send_stop <= stp;
    send_go <= 1'b1;
    @(posedge hclk);
    send_go <= 1'b0;
  endtask

  // read data checked at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_ph && exp_q.size() > 0) begin
      rd_m = msk_q.pop_front();
      check(hrdata & rd_m, exp_q.pop_front() & rd_m);
      check({31'h0, hresp}, 32'h0);
    end
    if (got_stb && fr_q.size() > 0)
      check({24'h0, got_byte}, {24'h0, fr_q.pop_front()});
  end

  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 8'h00, 32'h00, 32'hff);
    bus(0, 8'h04, 32'h00, 32'hff);
    bus(0, 8'h0c, 32'hc0, 32'hff);
    bus(0, 8'h08, 32'h00, 32'h4f);
    bus(0, 8'h14, 32'h00, 32'hffffffff);
    $display("test reset values done");
    // enables written while module is off must not stick
    bus(1, 8'h04, 32'h0c, 32'h0);
    bus(0, 8'h04, 32'h00, 32'hff);
    $display("test refused enable done");
    // odd parity, 8-bit: 0x35 has four ones so msb goes high
    bus(1, 8'h00, 32'h43, 32'h0);
    bus(0, 8'h00, 32'h43, 32'hff);
    bus(1, 8'h04, 32'h8c, 32'h0);
    repeat (4) @(posedge hclk);
    check({31'h0, tx_irq}, 32'h1);
    check({31'h0, txd}, 32'h1);
    bus(0, 8'h0c, 32'h80, 32'hc0);
    fr_q.push_back(8'hb5);
    bus(1, 8'h10, 32'h35, 32'h0);
    while (fr_q.size() > 0 && cyc < 11000) @(posedge hclk);
    check(32'(fr_q.size()), 32'h0);
    $display("test parity transmit done");
    // break set long after empty, then released: model reads zeros
    fr_q.push_back(8'h00);
    bus(1, 8'h04, 32'h8d, 32'h0);
    repeat (32) @(posedge hclk); // let the break load first
    bus(1, 8'h04, 32'h8c, 32'h0);
    while (fr_q.size() > 0 && cyc < 11000) @(posedge hclk);
    check(32'(fr_q.size()), 32'h0);
    $display("test break done");
    // random address-marked byte wakes standby, no parity
    rx_b = 8'($random(seed)) | 8'h80;
    bus(1, 8'h00, 32'h48, 32'h0);
    bus(1, 8'h04, 32'h2e, 32'h0);
    send(rx_b, 1'b1);
    wait_hi(rx_irq);
    bus(0, 8'h04, 32'h2c, 32'hff);
    bus(0, 8'h0c, 32'h20, 32'h20);
    bus(0, 8'h10, {24'h0, rx_b}, 32'hff);
    bus(0, 8'h08, {24'h0, rx_b[7], 7'h0}, 32'h80);
    bus(0, 8'h0c, 32'h00, 32'h20);
    repeat (3) @(posedge hclk);
    check({31'h0, rx_irq}, 32'h0);
    $display("test receive done");
    // stop bit low with framing enable set
    bus(1, 8'h08, 32'h02, 32'h0);
    send(8'h0f, 1'b0);
    wait_hi(err_irq);
    bus(0, 8'h0c, 32'h02, 32'h02);
    bus(1, 8'h04, 32'hc8, 32'h0);
    bus(0, 8'h0c, 32'h02, 32'h02);
    check({31'h0, tx_irq}, 32'h1);
    $display("test framing error done");
    bus(1, 8'h00, 32'h00, 32'h0);
    bus(0, 8'h0c, 32'hc0, 32'hc0);
    repeat (3) @(posedge hclk);
    check({31'h0, tx_irq}, 32'h0);
    $display("test module disable done");
    give_verdict();
  end
endmodule
